// *** watchdog_reset_flags_control_tb_top.sv ***
// Self-checking bench for the watchdog and reset-flag control block
`timescale 1ns/100ps

module watchdog_reset_flags_control_tb_top;
   localparam logic [7:0] OFS = wdc_pkg::WDCTL_OFFSET;
   localparam logic [7:0] TAO = wdc_pkg::TA_OFFSET;
   localparam int unsigned BEXP = 4;
   localparam int unsigned DLY = 512;

   logic       clk_sys = 1'b0, rstn = 1'b0, por_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
   logic [1:0] wdog_mode_sel = 2'h3;
   logic       wdog_irq_en = 1'b0, bandgap_stop_sel = 1'b0, rx_timer2_clk_sel = 1'b0;
   logic       tx_timer2_clk_sel = 1'b0, stop_mode = 1'b0, powerfail_event = 1'b0;
   wire logic [7:0] sfr_rdata;
   wire logic  baud_double, powerfail_irq, wdog_irq, wdog_timeout, wdog_reset_req;
   int         failures = 0, compares = 0, cyc = 0, rst_seen = 0, n, r0;

   wdc_watchdog_ctrl #(.BASE_EXP(BEXP), .CNT_W(12), .RST_DELAY(DLY), .TA_CYC(3)) DUT (
      .clk_sys, .rstn, .por_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .wdog_mode_sel, .wdog_irq_en, .bandgap_stop_sel, .rx_timer2_clk_sel, .tx_timer2_clk_sel,
      .stop_mode, .powerfail_event, .baud_double, .powerfail_irq, .wdog_irq, .wdog_timeout,
      .wdog_reset_req);

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (wdog_reset_req === 1'b1) rst_seen++;
      if (cyc == 12000) begin
         failures++;
         test_done();
      end
   end

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : step

   task wr(input logic [7:0] a, input logic [7:0] d);
      step(1);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      step(1);
      sfr_wr = 1'b0;
   endtask : wr

   task rd(input string nm, input logic [7:0] exp);
      step(1);
      sfr_rd = 1'b1;
      sfr_addr = OFS;
      step(1);
      sfr_rd = 1'b0;
      chk(nm, {8'h00, sfr_rdata}, {8'h00, exp});
   endtask : rd

   task ta_wr(input logic [7:0] d);
      wr(TAO, wdc_pkg::TA_KEY1);
      wr(TAO, wdc_pkg::TA_KEY2);
      wr(OFS, d);
   endtask : ta_wr

   // Waits for time-out (sel 0) or reset request (sel 1), counting cycles
   task wait_for(input bit sel, input int lim);
      n = 0;
      while ((sel ? wdog_reset_req : wdog_timeout) !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
   endtask : wait_for

   task test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   initial begin
      step(20);
      rstn = 1'b1;
      por_n = 1'b1;
      rd("reset value", 8'h40);
      wr(OFS, 8'hFF);
      rd("plain write", 8'hF4);
      step(1);
      chk("pf soft irq", powerfail_irq, 1);
      chk("baud on", baud_double, 1);
      rx_timer2_clk_sel = 1'b1;
      step(2);
      chk("baud rx sel", baud_double, 0);
      rx_timer2_clk_sel = 1'b0;
      tx_timer2_clk_sel = 1'b1;
      step(2);
      chk("baud tx sel", baud_double, 0);
      tx_timer2_clk_sel = 1'b0;
      stop_mode = 1'b1;
      step(2);
      chk("pf stop", powerfail_irq, 0);
      bandgap_stop_sel = 1'b1;
      step(2);
      chk("pf stop bgs", powerfail_irq, 1);
      stop_mode = 1'b0;
      bandgap_stop_sel = 1'b0;
      wr(OFS, 8'h00);
      rd("cleared", 8'h40);
      powerfail_event = 1'b1;
      step(1);
      powerfail_event = 1'b0;
      rd("pf event", 8'h50);
      $display("test register access done");
      ta_wr(8'h0A);
      rd("timed write", 8'h0A);
      wdog_irq_en = 1'b1;
      step(2);
      chk("soft wdog irq", wdog_irq, 1);
      ta_wr(8'h02);
      rd("timed clear", 8'h02);
      wr(TAO, wdc_pkg::TA_KEY1);
      wr(TAO, wdc_pkg::TA_KEY2);
      step(2);
      wr(OFS, 8'h00);
      rd("late write", 8'h02);
      rstn = 1'b0;
      step(2);
      rstn = 1'b1;
      rd("after sys reset", 8'h02);
      $display("test timed access done");
      wdog_irq_en = 1'b0;
      wdog_mode_sel = 2'h0;
      ta_wr(8'h03);
      wait_for(0, 40);
      chk("period mode 0", n, 16'd1 << BEXP);
      wait_for(1, DLY + 20);
      chk("reset delay", n, DLY);
      rd("after wdog reset", 8'h0E);
      chk("irq disabled", wdog_irq, 0);
      wdog_mode_sel = 2'h3;
      ta_wr(8'h03);
      wait_for(0, 1100);
      chk("period mode 3", n, 16'd1 << (BEXP + 6));
      wdog_irq_en = 1'b1;
      step(2);
      chk("wdog irq", wdog_irq, 1);
      r0 = rst_seen;
      ta_wr(8'h03);
      step(DLY + 8);
      chk("restart cancels", rst_seen - r0, 0);
      $display("test watchdog reset done");
      wdog_mode_sel = 2'h0;
      wr(OFS, 8'h00);
      ta_wr(8'h01);
      r0 = rst_seen;
      wait_for(0, 40);
      chk("counter runs", n, 16'd1 << BEXP);
      step(DLY + 8);
      chk("no reset when off", rst_seen - r0, 0);
      rd("flags when off", 8'h08);
      $display("test reset disabled done");
      test_done();
   end
endmodule : watchdog_reset_flags_control_tb_top

bind wdc_watchdog_ctrl wdc_watchdog_ctrl_monitor #(.RST_DELAY(RST_DELAY)) u_mon (
   .clk_sys, .rstn, .por_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
   .wdog_mode_sel, .wdog_irq_en, .bandgap_stop_sel, .rx_timer2_clk_sel, .tx_timer2_clk_sel,
   .stop_mode, .powerfail_event, .baud_double, .powerfail_irq, .wdog_irq, .wdog_timeout,
   .wdog_reset_req);

// *** wdc_pkg.sv ***
// Constants shared by the watchdog and reset-flag control block
package wdc_pkg;

   // Special-function register addresses
   localparam logic [7:0] WDCTL_OFFSET = 8'hD8;
   localparam logic [7:0] TA_OFFSET    = 8'hC7;

   // Bit positions in watchdog_power_flags_ctrl
   localparam int BAUD_DOUBLE_BIT   = 7;
   localparam int POR_FLAG_BIT      = 6;
   localparam int PF_IRQ_EN_BIT     = 5;
   localparam int PF_FLAG_BIT       = 4;
   localparam int WDOG_IRQ_FLAG_BIT = 3;
   localparam int WDOG_RST_FLAG_BIT = 2;
   localparam int WDOG_RST_EN_BIT   = 1;
   localparam int WDOG_RESTART_BIT  = 0;

   // Reset values
   localparam logic BAUD_DOUBLE_RST   = 1'h0;
   localparam logic POR_FLAG_RST      = 1'h1;
   localparam logic PF_IRQ_EN_RST     = 1'h0;
   localparam logic PF_FLAG_RST       = 1'h0;
   localparam logic WDOG_IRQ_FLAG_RST = 1'h0;
   localparam logic WDOG_RST_FLAG_RST = 1'h0;
   localparam logic WDOG_RST_EN_RST   = 1'h0;
   localparam logic [7:0] RDATA_RST   = 8'h00;

   // Timed-access unlock keys and open window
   localparam logic [7:0] TA_KEY1     = 8'hAA;
   localparam logic [7:0] TA_KEY2     = 8'h55;
   localparam int unsigned TA_OPEN_CYC = 3;

   // Watchdog timing
   localparam int unsigned WDOG_RST_DELAY_CYC = 512;
   localparam int unsigned WDOG_BASE_EXP      = 17;
   localparam int unsigned WDOG_CNT_W         = 24;

   // Unlock sequencer states
   typedef enum logic [1:0] {
      TA_IDLE,
      TA_ARMED,
      TA_OPEN
   } wdc_ta_state_t;

endpackage : wdc_pkg

// *** wdc_ta_unlock.sv ***
// Timed-access unlock sequencer for protected control bits
`timescale 1ns/100ps

module wdc_ta_unlock #(
   parameter int unsigned OPEN_CYC = wdc_pkg::TA_OPEN_CYC
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Register write port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   // Protected writes allowed
   output logic            ta_open
);

   generate
      if (OPEN_CYC < 1 || OPEN_CYC > 255) begin : g_chk
         $error("OPEN_CYC must be 1..255");
      end
   endgenerate

   wdc_pkg::wdc_ta_state_t state_q;
   wdc_pkg::wdc_ta_state_t state_d;
   logic [7:0]             left_q;
   logic [7:0]             left_d;
   logic                   ta_wr;

   assign ta_wr   = sfr_wr && (sfr_addr == wdc_pkg::TA_OFFSET);
   assign ta_open = (state_q == wdc_pkg::TA_OPEN);

   always_comb begin
      state_d = state_q;
      left_d  = left_q;
      case (state_q)
         wdc_pkg::TA_IDLE: begin
            if (ta_wr && sfr_wdata == wdc_pkg::TA_KEY1) begin
               state_d = wdc_pkg::TA_ARMED;
            end
         end
         wdc_pkg::TA_ARMED: begin
            // Second key opens the window, any other value written to the timed-access address aborts
            if (ta_wr) begin
               if (sfr_wdata == wdc_pkg::TA_KEY2) begin
                  state_d = wdc_pkg::TA_OPEN;
                  left_d  = OPEN_CYC[7:0];
               end else begin
                  state_d = wdc_pkg::TA_IDLE;
               end
            end
         end
         default: begin
            if (left_q <= 8'h01) begin
               state_d = wdc_pkg::TA_IDLE;
               left_d  = 8'h00;
            end else begin
               left_d = left_q - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= wdc_pkg::TA_IDLE;
         left_q  <= 8'h00;
      end else begin
         state_q <= state_d;
         left_q  <= left_d;
      end
   end

endmodule : wdc_ta_unlock

// *** wdc_watchdog_ctrl.sv ***
// Watchdog, power-fail and reset-flag control register block
`timescale 1ns/100ps

module wdc_watchdog_ctrl #(
   parameter int unsigned BASE_EXP  = wdc_pkg::WDOG_BASE_EXP,
   parameter int unsigned CNT_W     = wdc_pkg::WDOG_CNT_W,
   parameter int unsigned RST_DELAY = wdc_pkg::WDOG_RST_DELAY_CYC,
   parameter int unsigned TA_CYC    = wdc_pkg::TA_OPEN_CYC
) (
   // Clock and resets
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       por_n,
   // Special-function register port
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // Bits held in neighbouring registers
   input  wire logic [1:0] wdog_mode_sel,
   input  wire logic       wdog_irq_en,
   input  wire logic       bandgap_stop_sel,
   input  wire logic       rx_timer2_clk_sel,
   input  wire logic       tx_timer2_clk_sel,
   // System state and events
   input  wire logic       stop_mode,
   input  wire logic       powerfail_event,
   // Results
   output logic            baud_double,
   output logic            powerfail_irq,
   output logic            wdog_irq,
   output logic            wdog_timeout,
   output logic            wdog_reset_req
);

   generate
      if (BASE_EXP + 6 >= CNT_W || CNT_W > 31) begin : g_chk_cnt
         $error("CNT_W too small for the longest period");
      end
      if (RST_DELAY < 2 || RST_DELAY > 4096) begin : g_chk_dly
         $error("RST_DELAY must be 2..4096");
      end
   endgenerate

   // Last count of the selected period
   function automatic logic [CNT_W-1:0] period_last(
      input logic [1:0] mode
   );
      logic [CNT_W:0] one;
      one = {{CNT_W{1'b0}}, 1'b1};
      period_last = CNT_W'((one << (BASE_EXP + 2 * mode)) - 1'b1);
   endfunction : period_last

   // ---------------------------------------------------------------
   // Register access decode
   // ---------------------------------------------------------------
   logic ta_open;
   logic wr_hit;
   logic ta_wr;
   logic rd_hit;

   wdc_ta_unlock #(
      .OPEN_CYC (TA_CYC)
   ) u_ta (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .sfr_addr  (sfr_addr),
      .sfr_wr    (sfr_wr),
      .sfr_wdata (sfr_wdata),
      .ta_open   (ta_open)
   );

   assign wr_hit = sfr_wr && (sfr_addr == wdc_pkg::WDCTL_OFFSET);
   assign rd_hit = sfr_rd && (sfr_addr == wdc_pkg::WDCTL_OFFSET);
   assign ta_wr  = wr_hit && ta_open;

   // ---------------------------------------------------------------
   // Watchdog counter and delayed reset
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [12:0]      dly_q;
   logic [12:0]      dly_d;
   logic             pend_q;
   logic             pend_d;
   logic             req_q;
   logic             req_d;
   logic             expire;
   logic             restart;

   logic rst_en_q;
   logic rst_en_d;

   assign restart = ta_wr && sfr_wdata[wdc_pkg::WDOG_RESTART_BIT];
   assign expire  = (cnt_q == period_last(wdog_mode_sel));

   always_comb begin
      cnt_d  = cnt_q + 1'b1;
      dly_d  = dly_q;
      pend_d = pend_q;
      req_d  = 1'b0;
      if (restart) begin
         // Restart clears the count and cancels a pending reset
         cnt_d  = '0;
         pend_d = 1'b0;
         dly_d  = 13'h0000;
      end else begin
         if (expire) begin
            // Counter keeps running whatever the reset enable
            cnt_d = '0;
         end
         if (pend_q) begin
            // Request lands on the full delay count after the expiry edge
            if (dly_q == 13'(RST_DELAY - 1)) begin
               pend_d = 1'b0;
               req_d  = rst_en_q;
            end else begin
               dly_d = dly_q + 13'h0001;
            end
         end else if (expire) begin
            pend_d = 1'b1;
            dly_d  = 13'h0000;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= '0;
         dly_q  <= 13'h0000;
         pend_q <= 1'b0;
         req_q  <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         dly_q  <= dly_d;
         pend_q <= pend_d;
         req_q  <= req_d;
      end
   end

   // ---------------------------------------------------------------
   // Bits cleared by system reset, not by power-on reset
   // ---------------------------------------------------------------
   logic dbl_q;
   logic dbl_d;
   logic pf_en_q;
   logic pf_en_d;
   logic pf_flag_q;
   logic pf_flag_d;
   logic wd_flag_q;
   logic wd_flag_d;

   always_comb begin
      dbl_d     = dbl_q;
      pf_en_d   = pf_en_q;
      pf_flag_d = pf_flag_q;
      wd_flag_d = wd_flag_q;
      if (wr_hit) begin
         dbl_d     = sfr_wdata[wdc_pkg::BAUD_DOUBLE_BIT];
         pf_en_d   = sfr_wdata[wdc_pkg::PF_IRQ_EN_BIT];
         pf_flag_d = sfr_wdata[wdc_pkg::PF_FLAG_BIT];
      end
      if (ta_wr) begin
         wd_flag_d = sfr_wdata[wdc_pkg::WDOG_IRQ_FLAG_BIT];
      end
      // Hardware events win over a clearing write
      if (powerfail_event) begin
         pf_flag_d = 1'b1;
      end
      if (expire && !restart) begin
         wd_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dbl_q     <= wdc_pkg::BAUD_DOUBLE_RST;
         pf_en_q   <= wdc_pkg::PF_IRQ_EN_RST;
         pf_flag_q <= wdc_pkg::PF_FLAG_RST;
         wd_flag_q <= wdc_pkg::WDOG_IRQ_FLAG_RST;
      end else begin
         dbl_q     <= dbl_d;
         pf_en_q   <= pf_en_d;
         pf_flag_q <= pf_flag_d;
         wd_flag_q <= wd_flag_d;
      end
   end

   // ---------------------------------------------------------------
   // Bits touched only by power-on reset
   // ---------------------------------------------------------------
   logic por_q;
   logic por_d;
   logic rst_flag_q;
   logic rst_flag_d;

   always_comb begin
      por_d      = por_q;
      rst_en_d   = rst_en_q;
      rst_flag_d = rst_flag_q;
      if (ta_wr && !sfr_wdata[wdc_pkg::POR_FLAG_BIT]) begin
         por_d = 1'b0;
      end
      if (ta_wr) begin
         rst_en_d = sfr_wdata[wdc_pkg::WDOG_RST_EN_BIT];
      end
      if (wr_hit) begin
         // Software may set it; that does not reset the device
         rst_flag_d = sfr_wdata[wdc_pkg::WDOG_RST_FLAG_BIT];
      end
      if (req_d) begin
         rst_flag_d = 1'b1;
      end
   end

   // System reset leaves these bits alone
   always_ff @(posedge clk_sys or negedge por_n) begin
      if (!por_n) begin
         por_q      <= wdc_pkg::POR_FLAG_RST;
         rst_en_q   <= wdc_pkg::WDOG_RST_EN_RST;
         rst_flag_q <= wdc_pkg::WDOG_RST_FLAG_RST;
      end else begin
         por_q      <= por_d;
         rst_en_q   <= rst_en_d;
         rst_flag_q <= rst_flag_d;
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs and read data
   // ---------------------------------------------------------------
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic       bd_d;
   logic       bd_q;
   logic       pfirq_d;
   logic       pfirq_q;
   logic       wdirq_d;
   logic       wdirq_q;
   logic       tmo_q;

   always_comb begin
      bd_d = dbl_q && !rx_timer2_clk_sel && !tx_timer2_clk_sel;
      // Requests stay high while the flag and its enable are set; power-fail also needs stop_mode low or bandgap_stop_sel set
      pfirq_d = pf_flag_q && pf_en_q && (!stop_mode || bandgap_stop_sel);
      wdirq_d = wd_flag_q && wdog_irq_en;
      rdata_d = rdata_q;
      if (sfr_rd) begin
         rdata_d = 8'h00;
         if (rd_hit) begin
            rdata_d[wdc_pkg::BAUD_DOUBLE_BIT]   = dbl_q;
            rdata_d[wdc_pkg::POR_FLAG_BIT]      = por_q;
            rdata_d[wdc_pkg::PF_IRQ_EN_BIT]     = pf_en_q;
            rdata_d[wdc_pkg::PF_FLAG_BIT]       = pf_flag_q;
            rdata_d[wdc_pkg::WDOG_IRQ_FLAG_BIT] = wd_flag_q;
            rdata_d[wdc_pkg::WDOG_RST_FLAG_BIT] = rst_flag_q;
            rdata_d[wdc_pkg::WDOG_RST_EN_BIT]   = rst_en_q;
            rdata_d[wdc_pkg::WDOG_RESTART_BIT]  = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= wdc_pkg::RDATA_RST;
         bd_q    <= 1'b0;
         pfirq_q <= 1'b0;
         wdirq_q <= 1'b0;
         tmo_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         bd_q    <= bd_d;
         pfirq_q <= pfirq_d;
         wdirq_q <= wdirq_d;
         tmo_q   <= expire && !restart;
      end
   end

   assign sfr_rdata      = rdata_q;
   assign baud_double    = bd_q;
   assign powerfail_irq  = pfirq_q;
   assign wdog_irq       = wdirq_q;
   assign wdog_timeout   = tmo_q;
   assign wdog_reset_req = req_q;

endmodule : wdc_watchdog_ctrl

// *** wdc_watchdog_ctrl_monitor.sv ***
// Port-level checker for the watchdog and reset-flag control block
`timescale 1ns/100ps

module wdc_watchdog_ctrl_monitor #(
   parameter int unsigned RST_DELAY = 512
) (
   // Clock and resets
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       por_n,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Neighbouring bits and events
   input wire logic [1:0] wdog_mode_sel,
   input wire logic       wdog_irq_en,
   input wire logic       bandgap_stop_sel,
   input wire logic       rx_timer2_clk_sel,
   input wire logic       tx_timer2_clk_sel,
   input wire logic       stop_mode,
   input wire logic       powerfail_event,
   // Results
   input wire logic       baud_double,
   input wire logic       powerfail_irq,
   input wire logic       wdog_irq,
   input wire logic       wdog_timeout,
   input wire logic       wdog_reset_req
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // Unlock keys then a restart write, as the bench issues them
   sequence ta_restart;
      sfr_wr && sfr_addr == wdc_pkg::TA_OFFSET && sfr_wdata == wdc_pkg::TA_KEY1 ##2
      sfr_wr && sfr_addr == wdc_pkg::TA_OFFSET && sfr_wdata == wdc_pkg::TA_KEY2 ##2
      sfr_wr && sfr_addr == wdc_pkg::WDCTL_OFFSET && sfr_wdata[0];
   endsequence

   chk_baud_sel_gate: assert property ((rx_timer2_clk_sel || tx_timer2_clk_sel) |=> !baud_double)
      else $error("baud doubling active while a timer-2 clock select is set");
   chk_pf_stop_gate: assert property (stop_mode && !bandgap_stop_sel |=> !powerfail_irq)
      else $error("power-fail request in stop mode without band-gap select");
   chk_pf_soft_set: assert property (sfr_wr && sfr_addr == wdc_pkg::WDCTL_OFFSET && sfr_wdata[5:4] == 2'b11
      && !stop_mode ##1 !stop_mode |-> ##[0:1] powerfail_irq)
      else $error("software power-fail set gave no request");
   chk_wdog_irq_gate: assert property (!wdog_irq_en |=> !wdog_irq)
      else $error("watchdog request without its enable");
   chk_wdog_irq_follow: assert property (wdog_timeout && wdog_irq_en |=> wdog_irq || !wdog_irq_en)
      else $error("time-out with enable gave no watchdog request");
   chk_timeout_spacing: assert property (wdog_timeout |=> !wdog_timeout [*8])
      else $error("time-outs closer than the shortest period");
   chk_reset_delay: assert property (wdog_reset_req |-> $past(wdog_timeout, RST_DELAY))
      else $error("reset request not at the fixed delay after a time-out");
   chk_restart_clears: assert property (ta_restart |=> (!wdog_timeout && !wdog_reset_req) [*8])
      else $error("timed restart did not clear the count or pending reset");
   chk_restart_reads_zero: assert property (sfr_rd |=> !sfr_rdata[0])
      else $error("restart bit read back as one");

   cov_timeout: cover property (wdog_timeout);
   cov_reset_req: cover property (wdog_reset_req);
   cov_pf_irq: cover property (powerfail_irq);
endmodule : wdc_watchdog_ctrl_monitor
